/* pwm_pkg.sv */
// Purpose: Shared constants for the dual modulated / compare output block
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register words
// Notes:   Offsets are byte addresses of aligned 32-bit words
package pwm_pkg;

  // System clock rate in hertz
  localparam int unsigned CLK_HZ    = 100_000_000;
  // Duty value that means fully on
  localparam int unsigned DUTY_FULL = 32000;

  // Output operating modes
  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_PWM,
    MODE_CMP
  } out_mode_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CLEAR   = 8'h08;
  localparam logic [7:0] OFS_PRESET     [2] = '{8'h0c, 8'h10};
  // Duty word sits below its frequency word for each channel (see [RL11])
  localparam logic [7:0] OFS_DUTY       [2] = '{8'h14, 8'h1c};
  localparam logic [7:0] OFS_FREQ       [2] = '{8'h18, 8'h20};
  localparam logic [7:0] OFS_STOP_DUTY  [2] = '{8'h24, 8'h2c};
  localparam logic [7:0] OFS_STOP_FREQ  [2] = '{8'h28, 8'h30};
  localparam logic [7:0] OFS_TOTAL      [4] = '{8'h34, 8'h38, 8'h3c, 8'h40};

  // Control word field positions, channel n adds n (2n for the mode field)
  localparam int unsigned CTL_MODE_POS  = 0;  // Two bits per channel
  localparam int unsigned CTL_EN_POS    = 4;
  localparam int unsigned CTL_HOLD_POS  = 6;
  localparam int unsigned CTL_PLAIN_POS = 8;

  // Status word field positions, channel n adds n; the stop flag is one shared bit
  localparam int unsigned STS_OUT_POS   = 0;
  localparam int unsigned STS_ARM_POS   = 2;
  localparam int unsigned STS_STOP_POS  = 4;

  // Reset values
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [3:0]  CLEAR_RST   = 4'h0;

endpackage

/* cmp_output.sv */
// Purpose: Compare a fast counter total against its preset
// Assumes: Total and preset come from logic on the same clock
// Notes:   Output is high once the total has reached the preset
`timescale 1ns/1ns
module cmp_output (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Values compared
  input  wire logic [31:0] total_i,
  input  wire logic [31:0] preset_i,
  // Compare result
  output logic             hit_o
);

  // Registered compare
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hit_o <= 1'b0;
    else
      hit_o <= (total_i >= preset_i);  // see [RL10]
  end

  // Result tracks the previous cycle's comparison
  a_hit_follows: assert property (  // see [RL10]
    @(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> (hit_o == ($past(total_i) >= $past(preset_i))))
    else $error("compare result does not follow total and preset");

endmodule

/* pwm_channel.sv */
// Purpose: One pulse-width modulator channel
// Assumes: Duty in 1/32000 units, frequency in hertz, one system clock
// Notes:   Phase accumulator steps by the frequency and wraps at the clock rate
`timescale 1ns/1ns
module pwm_channel #(
  parameter int unsigned CLK_HZ = pwm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Settings
  input  wire logic        run_i,
  input  wire logic [31:0] duty_i,
  input  wire logic [31:0] freq_i,
  // Modulated level
  output logic             pwm_o
);

  localparam int unsigned ACC_W    = $clog2(CLK_HZ);
  localparam int unsigned SCALE    = CLK_HZ / pwm_pkg::DUTY_FULL;
  localparam int unsigned STEP_MAX = CLK_HZ / 2;
  localparam logic [ACC_W:0] WRAP  = (ACC_W + 1)'(CLK_HZ);
  localparam logic [31:0] FULL     = 32'(pwm_pkg::DUTY_FULL);

  // Clock must divide evenly into duty units
  if ((CLK_HZ % pwm_pkg::DUTY_FULL) != 0 || ACC_W > 31)
  begin : g_bad_clock
    $error("pwm_channel: clock rate not usable");
  end

  logic [ACC_W-1:0] acc_r;   // Elapsed phase, 0 .. CLK_HZ-1
  logic [31:0]      duty_c;  // Duty clamped to full scale
  logic [31:0]      step_c;  // Frequency clamped to half the clock
  logic [31:0]      thr_c;   // Phase below which output is high
  logic [ACC_W:0]   sum_c;   // Next phase before wrap

  // Scale duty and frequency into phase units
  always_comb
  begin
    duty_c = (duty_i > FULL) ? FULL : duty_i;
    step_c = (freq_i > STEP_MAX) ? 32'(STEP_MAX) : freq_i;
    thr_c  = duty_c * SCALE;  // see [RL4]
    sum_c  = {1'b0, acc_r} + step_c[ACC_W:0];
  end

  // Period accumulator, one period per CLK_HZ/freq cycles
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_r <= '0;
    else if (!run_i)
      acc_r <= '0;  // Restart period when idle
    else if (sum_c >= WRAP)
      acc_r <= ACC_W'(sum_c - WRAP);  // see [RL6] [RL12]
    else
      acc_r <= sum_c[ACC_W-1:0];
  end

  // High while elapsed fraction is below duty fraction
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= run_i && (duty_c != 32'h0) &&  // see [RL5]
               ((duty_c == FULL) ||
                ((freq_i != 32'h0) && (32'(acc_r) < thr_c)));  // see [RL12]
  end

  a_duty_zero_low: assert property (  // see [RL5]
    @(posedge clk_i) disable iff (!rst_n_i)
    (duty_i == 32'h0) |=> !pwm_o)
    else $error("zero duty did not hold output low");

  a_duty_full_high: assert property (  // see [RL5]
    @(posedge clk_i) disable iff (!rst_n_i)
    (run_i && duty_i == FULL) |=> pwm_o)
    else $error("full duty did not hold output high");

  a_phase_step: assert property (  // see [RL6]
    @(posedge clk_i) disable iff (!rst_n_i)
    (run_i && sum_c < WRAP) |=> (acc_r == $past(sum_c[ACC_W-1:0])))
    else $error("phase did not advance by the frequency");

  a_duty_compare: assert property (  // see [RL4]
    @(posedge clk_i) disable iff (!rst_n_i)
    (run_i && duty_c != 32'h0 && duty_c < FULL && freq_i != 32'h0)
    |=> (pwm_o == (32'($past(acc_r)) < $past(thr_c))))
    else $error("output level does not match duty fraction");

endmodule

/* dual_pwm_compare_output.sv */
// Purpose: Two dedicated outputs, each plain, modulated or counter compare
// Assumes: Avalon-MM slave with waitrequest, one 100 MHz clock
// Notes:   Every access takes two cycles; unmapped reads return zero
// Operation
// [RL1] Each output picks its own mode
// [RL2] Plain mode drives output from its bit
// [RL3] Modulated mode: own channel, own enable, settings
// [RL4] Duty 0..32000 gives high fraction duty/32000
// [RL5] Duty zero always low, full always high
// [RL6] Frequency in hertz sets output period
// [RL7] Low after start until duty, frequency non-zero
// [RL8] Stop mode holds state or uses stop settings
// [RL9] Zero stop duty or frequency holds low
// [RL10] Compare mode follows counter total versus preset
// [RL11] Software writes duty word before frequency word
// [RL12] Period counter; high while phase below duty
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
module dual_pwm_compare_output #(
  parameter int unsigned CLK_HZ = pwm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Controller state
  input  wire logic        STOP_MODE_I,
  input  wire logic        DOWNLOAD_I,
  // Fast counter totals
  input  wire logic [31:0] COUNTER_ONE_TOTAL_I,
  input  wire logic [31:0] COUNTER_TWO_TOTAL_I,
  input  wire logic [31:0] COUNTER_THREE_TOTAL_I,
  input  wire logic [31:0] COUNTER_FOUR_TOTAL_I,
  // Fast counter clear controls
  output logic             CLEAR_COUNTER_ONE_O,
  output logic             CLEAR_COUNTER_TWO_O,
  output logic             CLEAR_COUNTER_THREE_O,
  output logic             CLEAR_COUNTER_FOUR_O,
  // Dedicated outputs
  output logic             DEDICATED_OUTPUT_ONE_O,
  output logic             DEDICATED_OUTPUT_TWO_O
);

  logic        rst_meta_r;     // Reset release, first stage
  logic        rst_n;          // Reset release, second stage
  logic        waitrequest_r;  // Bus stall flag
  logic [31:0] readdata_r;     // Bus read data
  logic [31:0] control_r;      // Modes, enables, hold, plain bits
  logic [3:0]  clear_r;        // Counter clear bits
  logic [31:0] preset_r    [2];
  logic [31:0] duty_r      [2];
  logic [31:0] freq_r      [2];
  logic [31:0] stop_duty_r [2];
  logic [31:0] stop_freq_r [2];
  logic [31:0] total_c     [4];
  logic [1:0]  armed_r;        // Settings loaded since start
  logic [1:0]  out_r;          // Output pin levels
  logic [1:0]  run_c;          // Channel allowed to modulate
  logic [1:0]  pwm_c;          // Channel modulator level
  logic [1:0]  hit_c;          // Compare results
  logic [31:0] use_duty_c [2]; // Duty fed to channel
  logic [31:0] use_freq_c [2]; // Frequency fed to channel
  logic [31:0] rd_c;           // Read mux
  logic [31:0] status_c;       // Status word
  logic        wr_go;          // Write takes effect this edge
  logic [7:0]  ofs;            // Word-aligned byte offset

  // Merge write data by byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction

  // Reset released through two flops
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  assign total_c[0] = COUNTER_ONE_TOTAL_I;
  assign total_c[1] = COUNTER_TWO_TOTAL_I;
  assign total_c[2] = COUNTER_THREE_TOTAL_I;
  assign total_c[3] = COUNTER_FOUR_TOTAL_I;
  assign ofs        = {AVS_ADDRESS_I[7:2], 2'b00};
  assign wr_go      = AVS_WRITE_I && !waitrequest_r;

  // Waitrequest drops for one cycle per request
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest_r <= 1'b1;
    else if ((AVS_READ_I || AVS_WRITE_I) && waitrequest_r)
      waitrequest_r <= 1'b0;
    else
      waitrequest_r <= 1'b1;
  end

  // Status word shows live block state
  always_comb
  begin
    status_c = 32'h0;
    status_c[pwm_pkg::STS_OUT_POS +: 2] = out_r;
    status_c[pwm_pkg::STS_ARM_POS +: 2] = armed_r;
    status_c[pwm_pkg::STS_STOP_POS]     = STOP_MODE_I;
  end

  // Read mux, zero for unmapped offsets
  always_comb
  begin
    rd_c = 32'h0;
    if (ofs == pwm_pkg::OFS_CONTROL)
      rd_c = control_r;
    if (ofs == pwm_pkg::OFS_STATUS)
      rd_c = status_c;
    if (ofs == pwm_pkg::OFS_CLEAR)
      rd_c = {28'h0, clear_r};
    for (int c = 0; c < 2; c++)
    begin
      if (ofs == pwm_pkg::OFS_PRESET[c])
        rd_c = preset_r[c];
      if (ofs == pwm_pkg::OFS_DUTY[c])
        rd_c = duty_r[c];
      if (ofs == pwm_pkg::OFS_FREQ[c])
        rd_c = freq_r[c];
      if (ofs == pwm_pkg::OFS_STOP_DUTY[c])
        rd_c = stop_duty_r[c];
      if (ofs == pwm_pkg::OFS_STOP_FREQ[c])
        rd_c = stop_freq_r[c];
    end
    for (int t = 0; t < 4; t++)
      if (ofs == pwm_pkg::OFS_TOTAL[t])
        rd_c = total_c[t];
  end

  // Read data captured while stalled, stands at the completing edge
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      readdata_r <= 32'h0;
    else if (AVS_READ_I && waitrequest_r)
      readdata_r <= rd_c;
  end

  // Control and counter clear words
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_r <= pwm_pkg::CONTROL_RST;
      clear_r   <= pwm_pkg::CLEAR_RST;
    end
    else if (wr_go)
    begin
      if (ofs == pwm_pkg::OFS_CONTROL)
        control_r <= be_merge(control_r, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      if (ofs == pwm_pkg::OFS_CLEAR && AVS_BYTEENABLE_I[0])
        clear_r <= AVS_WRITEDATA_I[3:0];
    end
  end

  // Per-channel setting words
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        preset_r[c]    <= pwm_pkg::WORD_RST;
        duty_r[c]      <= pwm_pkg::WORD_RST;
        freq_r[c]      <= pwm_pkg::WORD_RST;
        stop_duty_r[c] <= pwm_pkg::WORD_RST;
        stop_freq_r[c] <= pwm_pkg::WORD_RST;
      end
    end
    else if (wr_go)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (ofs == pwm_pkg::OFS_PRESET[c])
          preset_r[c] <= be_merge(preset_r[c], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        if (ofs == pwm_pkg::OFS_DUTY[c])
          duty_r[c] <= be_merge(duty_r[c], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        if (ofs == pwm_pkg::OFS_FREQ[c])
          freq_r[c] <= be_merge(freq_r[c], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        if (ofs == pwm_pkg::OFS_STOP_DUTY[c])
          stop_duty_r[c] <= be_merge(stop_duty_r[c], AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I);
        if (ofs == pwm_pkg::OFS_STOP_FREQ[c])
          stop_freq_r[c] <= be_merge(stop_freq_r[c], AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I);
      end
    end
  end

  // Arm once duty and frequency are both non-zero; download disarms
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      armed_r <= 2'b00;
    else
      for (int c = 0; c < 2; c++)
        if (DOWNLOAD_I)
          armed_r[c] <= 1'b0;  // see [RL7]
        else if (duty_r[c] != 32'h0 && freq_r[c] != 32'h0)
          armed_r[c] <= 1'b1;  // see [RL7]
  end

  // Choose run condition and settings, normal or stop
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (STOP_MODE_I)
      begin
        use_duty_c[c] = stop_duty_r[c];  // see [RL8]
        use_freq_c[c] = stop_freq_r[c];
        run_c[c] = control_r[pwm_pkg::CTL_EN_POS + c] &&
                   stop_duty_r[c] != 32'h0 && stop_freq_r[c] != 32'h0;  // see [RL9]
      end
      else
      begin
        use_duty_c[c] = duty_r[c];
        use_freq_c[c] = freq_r[c];
        run_c[c] = control_r[pwm_pkg::CTL_EN_POS + c] && armed_r[c];  // see [RL3] [RL7]
      end
    end
  end

  // Modulator and compare unit per output
  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    pwm_channel #(
      .CLK_HZ (CLK_HZ)
    ) u_pwm (
      .clk_i   (REF_CLK_I),
      .rst_n_i (rst_n),
      .run_i   (run_c[g]),
      .duty_i  (use_duty_c[g]),
      .freq_i  (use_freq_c[g]),
      .pwm_o   (pwm_c[g])
    );
    cmp_output u_cmp (
      .clk_i    (REF_CLK_I),
      .rst_n_i  (rst_n),
      .total_i  (total_c[g]),
      .preset_i (preset_r[g]),
      .hit_o    (hit_c[g])
    );
  end

  // Output mode select per pin
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      out_r <= 2'b00;
    else
      for (int c = 0; c < 2; c++)
        unique case (pwm_pkg::out_mode_t'(
                       control_r[pwm_pkg::CTL_MODE_POS + 2*c +: 2]))  // see [RL1]
          pwm_pkg::MODE_PWM:
            if (STOP_MODE_I && control_r[pwm_pkg::CTL_HOLD_POS + c])
              out_r[c] <= out_r[c];  // Hold last state, see [RL8]
            else
              out_r[c] <= run_c[c] && pwm_c[c];  // see [RL3] [RL9]
          pwm_pkg::MODE_CMP:
            out_r[c] <= hit_c[c];  // see [RL10]
          default:
            out_r[c] <= control_r[pwm_pkg::CTL_PLAIN_POS + c];  // see [RL2]
        endcase
  end

  assign AVS_READDATA_O         = readdata_r;
  assign AVS_WAITREQUEST_O      = waitrequest_r;
  assign CLEAR_COUNTER_ONE_O    = clear_r[0];
  assign CLEAR_COUNTER_TWO_O    = clear_r[1];
  assign CLEAR_COUNTER_THREE_O  = clear_r[2];
  assign CLEAR_COUNTER_FOUR_O   = clear_r[3];
  assign DEDICATED_OUTPUT_ONE_O = out_r[0];
  assign DEDICATED_OUTPUT_TWO_O = out_r[1];

  a_plain_one: assert property (  // see [RL2]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (control_r[1:0] == 2'b00) |=> (out_r[0] == $past(control_r[8])))
    else $error("output one does not follow its plain bit");
  a_plain_two: assert property (  // see [RL2]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (control_r[3:2] == 2'b00) |=> (out_r[1] == $past(control_r[9])))
    else $error("output two does not follow its plain bit");
  a_compare_one: assert property (  // see [RL10]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (control_r[1:0] == 2'b10) |=> (out_r[0] == $past(hit_c[0])))
    else $error("output one does not follow its compare result");
  a_unarmed_low: assert property (  // see [RL7]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (control_r[1:0] == 2'b01 && !STOP_MODE_I && !armed_r[0]) |=> !out_r[0])
    else $error("modulated output high before settings loaded");
  a_download_disarm: assert property (  // see [RL7]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    DOWNLOAD_I |=> (armed_r == 2'b00))
    else $error("download did not disarm the channels");
  a_stop_zero_low: assert property (  // see [RL9]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (STOP_MODE_I && control_r[1:0] == 2'b01 && !control_r[6] &&
     (stop_duty_r[0] == 32'h0 || stop_freq_r[0] == 32'h0)) |=> !out_r[0])
    else $error("zero stop setting did not hold output low");
  a_stop_hold: assert property (  // see [RL8]
    @(posedge REF_CLK_I) disable iff (!rst_n)
    (STOP_MODE_I && control_r[1:0] == 2'b01 && control_r[6])
    |=> $stable(out_r[0]))
    else $error("stop hold did not keep the last state");
  a_wait_one_cycle: assert property (
    @(posedge REF_CLK_I) disable iff (!rst_n)
    ((AVS_READ_I || AVS_WRITE_I) && waitrequest_r) |=> !waitrequest_r ##1 waitrequest_r)
    else $error("waitrequest did not drop for exactly one cycle");

endmodule

/* pwm_load.sv */
// Purpose: Load model on one dedicated output pin
// Assumes: Pin level is sampled on the system clock
// Notes:   Counts high samples and rising edges since the last clear
`timescale 1ns/1ns
module pwm_load (
  // Clock
  input  wire logic       clk_i,
  // Observed pin and window control
  input  wire logic       level_i,
  input  wire logic       clear_i,
  // Window results
  output logic [7:0]      high_cnt_o,
  output logic [7:0]      rise_cnt_o
);
  logic prev_r;  // Level at previous edge

  // Previous level, kept across clears so the first edge counts
  always_ff @(posedge clk_i) prev_r <= level_i;

  // High time and rising edge counters
  always_ff @(posedge clk_i)
  begin
    if (clear_i)
    begin
      high_cnt_o <= 8'h00;
      rise_cnt_o <= 8'h00;
    end
    else
    begin
      high_cnt_o <= high_cnt_o + {7'h00, level_i};
      rise_cnt_o <= rise_cnt_o + {7'h00, level_i & ~prev_r};
    end
  end
endmodule

/* dual_pwm_compare_output_tb.sv */
// Purpose: Self-checking bench for the dual modulated / compare outputs
// Assumes: CLK_HZ shrunk to 320000, so duty step is 10 and 16000 Hz is 20 cycles
// Notes:   Reset checks and register rows first, then hand-written mode scenarios
`timescale 1ns/1ns
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module dual_pwm_compare_output_tb;
  // Register row: address, data, lanes, expected readback
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e;} row_t;
  logic        clk, rst_n, rd, wr, stop, dl, clr;  // Bench-driven controls
  logic [7:0]  addr;                                // Bus address
  logic [31:0] wdata, rv;                           // Write data, read value
  logic [3:0]  be;                                  // Byte lanes
  logic [31:0] tot [4];                             // Counter totals
  wire logic [31:0] rdata;                          // Read data
  wire logic        waitreq, out1, out2;            // Stall and pins
  wire logic [3:0]  clrs;                           // Counter clears
  wire logic [7:0]  hi1, ri1, hi2, ri2;             // Load window counts
  int errors, cmp_count, i;
  logic [31:0] duty [3] = '{32'h0, 32'h3e80, 32'h7d00};
  logic [7:0]  exh  [3] = '{8'd0, 8'd20, 8'd40};
  row_t rows [14] = '{
    '{pwm_pkg::OFS_STATUS, 32'hffffffff, 4'hf, 32'h0},
    '{pwm_pkg::OFS_PRESET[0], 32'haabbccdd, 4'hf, 32'haabbccdd},
    '{pwm_pkg::OFS_PRESET[0], 32'h11111111, 4'h1, 32'haabbcc11},
    '{pwm_pkg::OFS_PRESET[1], 32'h32, 4'hf, 32'h32},
    '{pwm_pkg::OFS_DUTY[0], 32'h1f40, 4'hf, 32'h1f40},
    '{pwm_pkg::OFS_FREQ[0], 32'h0, 4'hf, 32'h0},
    '{pwm_pkg::OFS_DUTY[1], 32'h0, 4'hf, 32'h0},
    '{pwm_pkg::OFS_FREQ[1], 32'h7d00, 4'hf, 32'h7d00},
    '{pwm_pkg::OFS_STOP_DUTY[0], 32'h12345678, 4'hf, 32'h12345678},
    '{pwm_pkg::OFS_STOP_DUTY[1], 32'h1f40, 4'hf, 32'h1f40},
    '{pwm_pkg::OFS_STOP_FREQ[1], 32'h0, 4'hf, 32'h0},
    '{pwm_pkg::OFS_TOTAL[0], 32'hffffffff, 4'hf, 32'h123},
    '{pwm_pkg::OFS_TOTAL[3], 32'h0, 4'hf, 32'h456},
    '{8'h44, 32'hffffffff, 4'hf, 32'h0}};

  dual_pwm_compare_output #(.CLK_HZ(320000)) dut (
    .REF_CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .STOP_MODE_I(stop),
    .DOWNLOAD_I(dl), .COUNTER_ONE_TOTAL_I(tot[0]), .COUNTER_TWO_TOTAL_I(tot[1]),
    .COUNTER_THREE_TOTAL_I(tot[2]), .COUNTER_FOUR_TOTAL_I(tot[3]),
    .CLEAR_COUNTER_ONE_O(clrs[0]), .CLEAR_COUNTER_TWO_O(clrs[1]),
    .CLEAR_COUNTER_THREE_O(clrs[2]), .CLEAR_COUNTER_FOUR_O(clrs[3]),
    .DEDICATED_OUTPUT_ONE_O(out1), .DEDICATED_OUTPUT_TWO_O(out2));
  pwm_load load_one (.clk_i(clk), .level_i(out1), .clear_i(clr),
    .high_cnt_o(hi1), .rise_cnt_o(ri1));
  pwm_load load_two (.clk_i(clk), .level_i(out2), .clear_i(clr),
    .high_cnt_o(hi2), .rise_cnt_o(ri2));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One bus access, held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    do
    begin
      @(posedge clk);
    end
    while (waitreq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Settle, then count both pins over a 40-cycle window; returns on an edge
  task automatic measure();
    repeat (6) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (41) @(posedge clk);
  endtask

  // Counts and verdict
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #200000;
    `CHK(1'b0, 1'b1, "watchdog expired")
    conclude();
  end

  // Main sequence
  initial
  begin
    {rst_n, rd, wr, stop, dl, clr} = 6'h00;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hf;
    tot = '{32'h123, 32'h0, 32'h0, 32'h456};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({out1, out2, waitreq, clrs}, 7'h10, "reset pin state")
    bus(1'b0, pwm_pkg::OFS_CONTROL, 32'h0, 4'hf);
    `CHK(rv, pwm_pkg::CONTROL_RST, "control reset value")
    $display("reset test done");
    // Register rows: write, then read back
    for (i = 0; i < 14; i++)
    begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
      bus(1'b0, rows[i].a, 32'h0, 4'hf);
      `CHK(rv, rows[i].e, "register readback")
    end
    $display("register rows done");
    // Plain mode, each pin from its own bit
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h200, 4'hf);
    repeat (3) @(posedge clk);
    `CHK({out1, out2}, 2'b01, "plain bit two")
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h100, 4'hf);
    repeat (3) @(posedge clk);
    `CHK({out1, out2}, 2'b10, "plain bit one")
    $display("plain test done");
    // Both modulated; frequency one still zero, duty two zero
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h35, 4'hf);
    measure();
    `CHK({hi1, hi2}, 16'h0, "unloaded channels stay low")
    bus(1'b1, pwm_pkg::OFS_FREQ[0], 32'h3e80, 4'hf);
    bus(1'b1, pwm_pkg::OFS_DUTY[1], 32'h3e80, 4'hf);
    measure();
    `CHK({hi1, ri1}, {8'd10, 8'd2}, "quarter duty at 16000 Hz")
    `CHK({hi2, ri2}, {8'd20, 8'd4}, "half duty at 32000 Hz")
    for (i = 0; i < 3; i++)
    begin
      bus(1'b1, pwm_pkg::OFS_DUTY[0], duty[i], 4'hf);
      measure();
      `CHK(hi1, exh[i], "duty sweep high time")
    end
    $display("modulation test done");
    // Outputs low while a download is in progress
    dl <= 1'b1;
    measure();
    `CHK({hi1, hi2}, 16'h0, "low during download")
    dl <= 1'b0;
    bus(1'b1, pwm_pkg::OFS_DUTY[0], 32'h1f40, 4'hf);
    bus(1'b1, pwm_pkg::OFS_FREQ[0], 32'h3e80, 4'hf);
    measure();
    `CHK(hi1, 8'd10, "reloaded after download")
    $display("download test done");
    // Stop mode: channel one holds, channel two uses stop settings
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h75, 4'hf);
    stop <= 1'b1;
    measure();
    `CHK({ri1, (hi1 === 8'd0 || hi1 === 8'd40)}, 9'h001, "held level")
    `CHK(hi2, 8'd0, "zero stop frequency low")
    bus(1'b0, pwm_pkg::OFS_STATUS, 32'h0, 4'hf);
    `CHK(rv[4:2], 3'b111, "stop and armed flags in status")
    bus(1'b1, pwm_pkg::OFS_STOP_FREQ[1], 32'h3e80, 4'hf);
    measure();
    `CHK(hi2, 8'd10, "stop settings applied")
    stop <= 1'b0;
    $display("stop test done");
    // Compare mode against presets
    tot[0] <= 32'd99;
    tot[1] <= 32'd60;
    bus(1'b1, pwm_pkg::OFS_PRESET[0], 32'd100, 4'hf);
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'ha, 4'hf);
    repeat (4) @(posedge clk);
    `CHK({out1, out2}, 2'b01, "compare below and above")
    tot[0] <= 32'd100;
    repeat (4) @(posedge clk);
    `CHK(out1, 1'b1, "compare reached")
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h8, 4'hf);
    repeat (4) @(posedge clk);
    `CHK({out1, out2}, 2'b01, "modes chosen per pin")
    // Mode code three on both pins acts as plain
    bus(1'b1, pwm_pkg::OFS_CONTROL, 32'h10f, 4'hf);
    repeat (4) @(posedge clk);
    `CHK({out1, out2}, 2'b10, "mode code three is plain")
    bus(1'b1, pwm_pkg::OFS_CLEAR, 32'h5, 4'hf);
    repeat (2) @(posedge clk);
    `CHK(clrs, 4'h5, "counter clear levels")
    $display("compare test done");
    // Reset in mid-run clears pins and registers
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({out1, out2, waitreq, clrs}, 7'h10, "mid-run reset pin state")
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, pwm_pkg::OFS_PRESET[0], 32'h0, 4'hf);
    `CHK(rv, pwm_pkg::WORD_RST, "preset reset value")
    $display("mid-run reset test done");
    conclude();
  end
endmodule
